// *** fdc_pkg.sv ***
// Constants, types and state layouts shared by the flash driver control logic.
// Assumes one 40 MHz clock and register access over the two-wire serial bus only.
//
// Overview of operation
// - Control write 0x20 selects assist mode, default current.
// - Control readback returns 0x20 unless coil broken.
// - Control write 0x00 powers output off, shutdown.
// - Fault register reads 0x00 with healthy LED.
// - LED short during operation sets short flag.
// - Open LED overvoltage sets overvoltage flag.
// - Key 0xA1 at 0x80 unlocks next write only.
// - Unlocked 0xFF current write selects 500mA range.
// - Control write 0x3F fires timed 480ms flash.
// - Device returns to shutdown after flash unaided.
// - Any protection error disables source and boost.
// - Mode bits 5:4: off, indicator, assist, flash.
// - Duration bits 3:0: 30ms steps, 30 to 480ms.
// - Fault bits: 7 overvoltage, 6 short, 5 overtemp.
package fdc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [7:0] FDC_ADDR_CUR = 8'h02;    // LED current setting.
  localparam logic [7:0] FDC_ADDR_CTRL = 8'h03;   // Operating control.
  localparam logic [7:0] FDC_ADDR_FAULT = 8'h04;  // Fault flags, read only.
  localparam logic [7:0] FDC_ADDR_UNLOCK = 8'h80; // Unlock password, write only.
  localparam logic [7:0] FDC_UNLOCK_KEY = 8'ha1;  // Value that unlocks the next write.
  localparam logic [7:0] FDC_CUR_RESET = 8'hb4;   // Current setting after reset.
  localparam logic [7:0] FDC_CTRL_RESET = 8'h04;  // Control after reset: off, 150 ms.

  // Field positions.
  localparam int FDC_CTRL_STROBE_BIT = 7;  // External strobe enable.
  localparam int FDC_CTRL_MODE_LSB = 4;    // Two-bit operating mode.
  localparam int FDC_CTRL_TIMER_LSB = 0;   // Four-bit flash duration.
  localparam int FDC_CUR_MODE_LSB = 0;     // Two-bit current range select.
  localparam int FDC_FAULT_OVP_BIT = 7;    // Output overvoltage.
  localparam int FDC_FAULT_SHORT_BIT = 6;  // LED output short.
  localparam int FDC_FAULT_TEMP_BIT = 5;   // Overtemperature.
  localparam int FDC_FAULT_FLAG_LSB = 5;   // Lowest flag bit; bits below read zero.

  //////////////////////////////////////////////////////////////////////////////
  // Flash timing: one duration step is 30 ms, counted at the system clock.
  localparam int FDC_CLK_FREQ_HZ = 40_000_000;  // System clock rate.
  localparam int FDC_FLASH_STEP_MS = 30;         // Duration of one timer code step.
  localparam int FDC_FLASH_STEP_CYC = FDC_FLASH_STEP_MS * (FDC_CLK_FREQ_HZ / 1000);
  localparam int FDC_PRESCALE_W = 21;            // Wide enough for one step count.

  //////////////////////////////////////////////////////////////////////////////
  // Operating modes as encoded in the control register.
  typedef enum logic [1:0] {
    FDC_MODE_OFF = 2'b00,     // Shutdown.
    FDC_MODE_IND = 2'b01,     // Indicator light.
    FDC_MODE_ASSIST = 2'b10,  // Assist or torch light.
    FDC_MODE_FLASH = 2'b11    // Timed flash.
  } fdc_mode_t;

  // Serial slave states, Gray coded along the usual transfer path.
  typedef enum logic [3:0] {
    FDC_BUS_IDLE = 4'b0000,
    FDC_BUS_ADDR = 4'b0001,
    FDC_BUS_ACK_ADDR = 4'b0011,
    FDC_BUS_REG = 4'b0010,
    FDC_BUS_ACK_REG = 4'b0110,
    FDC_BUS_WDATA = 4'b0111,
    FDC_BUS_ACK_WDATA = 4'b0101,
    FDC_BUS_RDATA = 4'b0100,
    FDC_BUS_RACK = 4'b1100
  } fdc_bus_state_t;

  // Whole state of the top module.
  typedef struct packed {
    fdc_bus_state_t st;  // Serial slave state.
    logic scl_q;         // Clock line one cycle ago.
    logic sda_q;         // Data line one cycle ago.
    logic [3:0] bits;    // Bits moved in the current byte.
    logic [7:0] shreg;   // Receive shift register.
    logic [7:0] ptr;     // Register address of this transfer.
    logic rw;            // Read request flag.
    logic [7:0] tx;      // Transmit shift register.
    logic sda_oe;        // Pull the data line low.
    logic sda_out;       // Level driven when enabled, always low.
    logic [7:0] cur;     // Current setting register.
    logic [3:0] timer_code;  // Flash duration code.
    fdc_mode_t mode;     // Operating mode.
    logic strobe;        // External strobe enable bit.
    logic unlocked;      // Next write may change protected fields.
    logic start;         // Pulse that launches the flash timer.
    logic clear;         // Pulse that clears the fault flags.
    logic boost_en;      // Boost converter enable.
    logic src_en;        // Current source enable.
  } fdc_top_state_t;

  // State of the flash duration timer.
  typedef struct packed {
    logic busy;                        // Timing a flash.
    logic [FDC_PRESCALE_W-1:0] pre;    // Cycles within the current step.
    logic [3:0] step;                  // Steps completed.
    logic expired;                     // Pulse at the end of the flash.
  } fdc_timer_state_t;

  // State of the fault latch.
  typedef struct packed {
    logic [2:0] flags;  // Overvoltage, short, overtemperature.
    logic trip;         // Pulse on any fault seen while active.
  } fdc_fault_state_t;

endpackage

// *** fdc_core_if.sv ***
// Interface carrying timer and fault signals between the control top and its helpers.
// Assumes all members change on the rising edge of the single system clock.
`timescale 1ns/1ps
`default_nettype none

interface fdc_core_if;
  logic start;           // Launch a flash duration count.
  logic run;             // Flash mode still selected; low aborts the count.
  logic [3:0] dur_code;  // Duration code of the flash.
  logic expired;         // End of the flash duration.
  logic active;          // Output stage is powered.
  logic [2:0] detect;    // Raw overvoltage, short and overtemperature levels.
  logic clear;           // Clear the fault flags.
  logic [2:0] flags;     // Sticky fault flags.
  logic trip;            // A fault was seen while active.

  modport ctrl (output start, run, dur_code, active, detect, clear,
                input expired, flags, trip);
  modport timer (input start, run, dur_code, output expired);
  modport fault (input active, detect, clear, output flags, trip);
endinterface

`default_nettype wire

// *** fdc_timer.sv ***
// Flash duration timer: counts whole 30 ms steps after a start pulse.
// Assumes the start pulse is one cycle long and run stays high through the flash.
`timescale 1ns/1ps
`default_nettype none

module fdc_timer #(
  parameter int STEP_CYCLES = fdc_pkg::FDC_FLASH_STEP_CYC  // Cycles per duration step.
) (
  input wire logic sys_clk,   // System clock.
  input wire logic resetn,    // Asynchronous reset, active low.
  fdc_core_if.timer tmr       // Start, abort and expiry signals.
);
  import fdc_pkg::*;

  localparam logic [FDC_PRESCALE_W-1:0] PRE_LAST = FDC_PRESCALE_W'(STEP_CYCLES - 1);

  fdc_timer_state_t s;       // Registered state.
  fdc_timer_state_t next_s;  // Next state.

  //////////////////////////////////////////////////////////////////////////////
  // Next state. A flash lasts (code + 1) steps; leaving flash mode aborts it silently.
  always_comb begin
    next_s = s;
    next_s.expired = 1'b0;
    if (tmr.start) begin
      // A new start always reloads, so a rewrite restarts the duration.
      next_s.busy = 1'b1;
      next_s.pre = '0;
      next_s.step = '0;
    end else if (s.busy && !tmr.run) begin
      next_s.busy = 1'b0;
    end else if (s.busy) begin
      if (s.pre == PRE_LAST) begin
        next_s.pre = '0;
        if (s.step == tmr.dur_code) begin
          next_s.busy = 1'b0;
          next_s.expired = 1'b1;
        end else begin
          next_s.step = s.step + 4'h1;
        end
      end else begin
        next_s.pre = s.pre + FDC_PRESCALE_W'(1);
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tmr.expired = s.expired;
endmodule

`default_nettype wire

// *** fdc_fault.sv ***
// Fault latch: sticky overvoltage, short and overtemperature flags.
// Assumes detector levels are already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none

module fdc_fault (
  input wire logic sys_clk,  // System clock.
  input wire logic resetn,   // Asynchronous reset, active low.
  fdc_core_if.fault flt      // Detector levels, clear and flags.
);
  import fdc_pkg::*;

  fdc_fault_state_t s;       // Registered state.
  fdc_fault_state_t next_s;  // Next state.
  logic [2:0] hit;           // Detectors firing while the output is powered.

  //////////////////////////////////////////////////////////////////////////////
  // Flags only count while powered, so an idle unconnected LED reads clean.
  // A detection in the clearing cycle wins, so no event is lost.
  always_comb begin
    hit = flt.detect & {3{flt.active}};
    next_s.flags = (flt.clear ? 3'b000 : s.flags) | hit;
    next_s.trip = |hit;
  end

  // State register.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flt.flags = s.flags;
  assign flt.trip = s.trip;
endmodule

`default_nettype wire

// *** fdc_top.sv ***
// Flash driver control: serial register slave, mode control, flash timing, faults.
// Assumes bus lines are synchronous to sys_clk and far slower than it.
`timescale 1ns/1ps
`default_nettype none

module fdc_top #(
  parameter logic [6:0] DEV_ADDR = 7'h30,  // Bus address of the device.
  parameter int STEP_CYCLES = fdc_pkg::FDC_FLASH_STEP_CYC  // Cycles per 30 ms step.
) (
  input wire logic sys_clk,             // System clock, 40 MHz.
  input wire logic resetn,              // Asynchronous reset, active low.
  input wire logic scl,                 // Serial bus clock.
  input wire logic sda_in,              // Serial data line level.
  output logic sda_out,                 // Serial data drive level, always low.
  output logic sda_oe,                  // High while the device pulls data low.
  input wire logic ovp_detect,          // Boost output above its limit.
  input wire logic short_detect,        // LED output shorted.
  input wire logic overtemp_detect,     // Junction temperature too high.
  input wire logic boost_inductor_open, // Broken coil seen by the boost stage.
  output logic boost_en,                // Boost converter enable.
  output logic current_src_en,          // LED current source enable.
  output fdc_pkg::fdc_mode_t led_mode,  // Operating mode in force.
  output logic [7:0] led_current        // Current setting for the source.
);
  import fdc_pkg::*;

  fdc_top_state_t s;       // Registered state.
  fdc_top_state_t next_s;  // Next state.
  fdc_core_if core ();     // Link to timer and fault helpers.

  logic scl_rise;   // Clock line rose.
  logic scl_fall;   // Clock line fell.
  logic bus_start;  // Start condition.
  logic bus_stop;   // Stop condition.
  logic wr;         // A complete data byte was written.
  logic [7:0] rd;   // Read data for the addressed register.
  logic [1:0] wmode;  // Mode field of the written byte.
  logic keep_mode;  // Locked write tried to enter indicator mode.
  logic power_cut;  // Protection shuts the output stage down.

  //////////////////////////////////////////////////////////////////////////////
  // Register read decode, used when a read byte is loaded.
  function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                          input fdc_top_state_t st,
                                          input logic [2:0] flags);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      FDC_ADDR_CUR: v = st.cur;
      // Reserved bit 6 reads zero; a coil trip shows as a changed mode.
      FDC_ADDR_CTRL: v = {st.strobe, 1'b0, st.mode, st.timer_code};
      FDC_ADDR_FAULT: v = {flags, 5'h00};
      default: v = 8'h00;  // Unmapped and write-only addresses read zero.
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus line edges and conditions, from the current and last sampled levels.
  always_comb begin
    scl_rise = scl && !s.scl_q;
    scl_fall = !scl && s.scl_q;
    bus_start = scl && s.scl_q && s.sda_q && !sda_in;
    bus_stop = scl && s.scl_q && !s.sda_q && sda_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state: serial slave, then register writes, then mode sequencing.
  always_comb begin
    next_s = s;
    next_s.scl_q = scl;
    next_s.sda_q = sda_in;
    next_s.start = 1'b0;
    next_s.clear = 1'b0;
    next_s.sda_out = 1'b0;
    wr = 1'b0;
    rd = read_reg(s.ptr, s, core.flags);
    wmode = s.shreg[FDC_CTRL_MODE_LSB +: 2];
    keep_mode = 1'b0;
    power_cut = 1'b0;

    // Serial slave. A start always restarts, a stop always releases the line.
    if (bus_start) begin
      next_s.st = FDC_BUS_ADDR;
      next_s.bits = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_s.st = FDC_BUS_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.st)
        FDC_BUS_ADDR, FDC_BUS_REG, FDC_BUS_WDATA: begin
          if (scl_rise && s.bits != 4'h8) begin
            next_s.shreg = {s.shreg[6:0], sda_in};
            next_s.bits = s.bits + 4'h1;
          end else if (scl_fall && s.bits == 4'h8) begin
            next_s.sda_oe = 1'b1;  // Acknowledge by default.
            if (s.st == FDC_BUS_ADDR) begin
              next_s.rw = s.shreg[0];
              if (s.shreg[7:1] == DEV_ADDR) begin
                next_s.st = FDC_BUS_ACK_ADDR;
              end else begin
                // Another device is addressed: stay off the line.
                next_s.sda_oe = 1'b0;
                next_s.st = FDC_BUS_IDLE;
              end
            end else if (s.st == FDC_BUS_REG) begin
              next_s.ptr = s.shreg;
              next_s.st = FDC_BUS_ACK_REG;
            end else begin
              wr = 1'b1;
              next_s.st = FDC_BUS_ACK_WDATA;
            end
          end
        end
        FDC_BUS_ACK_ADDR: begin
          if (scl_fall) begin
            next_s.bits = 4'h0;
            if (s.rw) begin
              // Load the byte and drive its first bit; open drain pulls only zeros.
              next_s.tx = rd;
              next_s.sda_oe = !rd[7];
              next_s.st = FDC_BUS_RDATA;
              next_s.clear = (s.ptr == FDC_ADDR_FAULT);
            end else begin
              next_s.sda_oe = 1'b0;
              next_s.st = FDC_BUS_REG;
            end
          end
        end
        FDC_BUS_ACK_REG: begin
          if (scl_fall) begin
            next_s.sda_oe = 1'b0;
            next_s.bits = 4'h0;
            next_s.st = FDC_BUS_WDATA;
          end
        end
        FDC_BUS_ACK_WDATA: begin
          // One byte per transfer: later bytes see no acknowledge.
          if (scl_fall) begin
            next_s.sda_oe = 1'b0;
            next_s.st = FDC_BUS_IDLE;
          end
        end
        FDC_BUS_RDATA: begin
          if (scl_fall) begin
            if (s.bits == 4'h7) begin
              next_s.sda_oe = 1'b0;
              next_s.st = FDC_BUS_RACK;
            end else begin
              next_s.tx = {s.tx[6:0], 1'b0};
              next_s.sda_oe = !s.tx[6];
              next_s.bits = s.bits + 4'h1;
            end
          end
        end
        FDC_BUS_RACK: begin
          if (scl_fall) begin
            next_s.st = FDC_BUS_IDLE;
          end
        end
        FDC_BUS_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        default: begin
          next_s.st = FDC_BUS_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end

    // Register writes. Any write other than the key consumes the unlock.
    if (wr) begin
      if (s.ptr == FDC_ADDR_UNLOCK) begin
        next_s.unlocked = (s.shreg == FDC_UNLOCK_KEY);
      end else begin
        next_s.unlocked = 1'b0;
        case (s.ptr)
          FDC_ADDR_CUR: begin
            // The range select is protected against accidental high currents.
            next_s.cur = s.shreg;
            if (!s.unlocked) begin
              next_s.cur[FDC_CUR_MODE_LSB +: 2] = s.cur[FDC_CUR_MODE_LSB +: 2];
            end
          end
          FDC_ADDR_CTRL: begin
            next_s.timer_code = s.shreg[FDC_CTRL_TIMER_LSB +: 4];
            keep_mode = (wmode == FDC_MODE_IND) && !s.unlocked &&
                        (s.mode != FDC_MODE_IND);
            if (!keep_mode) begin
              next_s.mode = fdc_mode_t'(wmode);
            end
            if (s.unlocked) begin
              next_s.strobe = s.shreg[FDC_CTRL_STROBE_BIT];
            end
            // Flash fires straight away on entering flash mode.
            next_s.start = !keep_mode && (wmode == FDC_MODE_FLASH);
          end
          default: begin
            // Fault register is read only; other addresses are ignored.
          end
        endcase
      end
    end

    // End of flash and protection both return to shutdown with no bus traffic.
    power_cut = core.trip || (boost_inductor_open && s.boost_en);
    if (core.expired && s.mode == FDC_MODE_FLASH) begin
      next_s.mode = FDC_MODE_OFF;
    end
    if (power_cut) begin
      next_s.mode = FDC_MODE_OFF;
      next_s.start = 1'b0;
    end

    // Output stage follows the mode; shutdown powers both parts down.
    next_s.boost_en = (next_s.mode != FDC_MODE_OFF);
    next_s.src_en = (next_s.mode != FDC_MODE_OFF);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register, with documented register reset values.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.st <= FDC_BUS_IDLE;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.cur <= FDC_CUR_RESET;
      s.timer_code <= FDC_CTRL_RESET[FDC_CTRL_TIMER_LSB +: 4];
      s.mode <= FDC_MODE_OFF;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Helper connections.
  assign core.start = s.start;
  assign core.run = (s.mode == FDC_MODE_FLASH);
  assign core.dur_code = s.timer_code;
  assign core.active = s.boost_en;
  assign core.detect = {ovp_detect, short_detect, overtemp_detect};
  assign core.clear = s.clear;

  fdc_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tmr(core)
  );

  fdc_fault u_fault (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .flt(core)
  );

  // Outputs come straight from state flip-flops.
  assign sda_out = s.sda_out;
  assign sda_oe = s.sda_oe;
  assign boost_en = s.boost_en;
  assign current_src_en = s.src_en;
  assign led_mode = s.mode;
  assign led_current = s.cur;
endmodule

`default_nettype wire

// *** fdc_chk.sv ***
// Checker for the flash driver control top, watching its ports only.
// Assumes a bind to fdc_top with a short duration step.
`timescale 1ns/1ps
`default_nettype none

module fdc_chk #(
  parameter int STEP_CYCLES = 20 // Cycles per duration step.
) (
  input wire logic sys_clk, // Clock.
  input wire logic resetn, // Reset, active low.
  input wire logic scl, // Bus clock.
  input wire logic sda_in, // Data line.
  input wire logic sda_out, // Drive level.
  input wire logic sda_oe, // Pull enable.
  input wire logic ovp_detect, // Overvoltage.
  input wire logic short_detect, // LED short.
  input wire logic overtemp_detect, // Overtemperature.
  input wire logic boost_inductor_open, // Broken coil.
  input wire logic boost_en, // Boost enable.
  input wire logic current_src_en, // Source enable.
  input wire fdc_pkg::fdc_mode_t led_mode, // Mode.
  input wire logic [7:0] led_current // Current.
);
  import fdc_pkg::*;
  // Longest flash plus commit slack.
  localparam int FL_MAX = 16 * STEP_CYCLES + 6;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////////
  en_pair_a: assert property (current_src_en == boost_en)
    else $error("source and boost enables differ");
  off_state_a: assert property (led_mode == FDC_MODE_OFF |-> !boost_en)
    else $error("boost on in shutdown");
  ovp_trip_a: assert property (boost_en && ovp_detect |-> ##[1:3] !boost_en)
    else $error("overvoltage did not stop output");
  short_trip_a: assert property (boost_en && short_detect |-> ##[1:3] !boost_en)
    else $error("short did not stop output");
  coil_trip_a: assert property (boost_en && boost_inductor_open |->
    ##[1:2] led_mode == FDC_MODE_OFF)
    else $error("broken coil left mode on");
  flash_end_a: assert property ($rose(led_mode == FDC_MODE_FLASH) |->
    ##[1:FL_MAX] led_mode == FDC_MODE_OFF)
    else $error("flash did not end");
  // Open drain must only move while the clock line is low.
  oe_move_a: assert property ($changed(sda_oe) |-> !scl && !$past(scl))
    else $error("data drive moved with clock high");
  cur_commit_a: assert property ($changed(led_current) |-> $rose(sda_oe))
    else $error("current changed off a data acknowledge");
  boost_start_a: assert property ($rose(boost_en) |-> sda_oe && !scl)
    else $error("output started off a control write");
  cover property ($rose(led_mode == FDC_MODE_FLASH));
  cover property (boost_en && short_detect);
  cover property ($fell(boost_en) && led_mode == FDC_MODE_OFF);
endmodule

bind fdc_top fdc_chk #(.STEP_CYCLES(STEP_CYCLES)) fdc_chk_inst (.sys_clk(sys_clk),
  .resetn(resetn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .ovp_detect(ovp_detect), .short_detect(short_detect), .overtemp_detect(overtemp_detect),
  .boost_inductor_open(boost_inductor_open), .boost_en(boost_en),
  .current_src_en(current_src_en), .led_mode(led_mode), .led_current(led_current));

`default_nettype wire

// *** fdc_host.sv ***
// Host model: two-wire bus master making single-byte register accesses.
// Assumes the bench resolves the pulled-up data line from both parties.
`timescale 1ns/1ps
`default_nettype none

module fdc_host #(
  parameter logic [6:0] DEV_ADDR = 7'h30 // Device bus address.
) (
  input wire logic sys_clk, // System clock.
  input wire logic sda_line, // Resolved data line.
  output logic scl, // Bus clock, idle high.
  output logic sda_low // High while the host pulls data low.
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Five clocks a phase, above the slave's four-cycle minimum.
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_low <= !b;
    tk(5);
    scl <= 1'b1;
    tk(5);
    r = sda_line;
    scl <= 1'b0;
    tk(1);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    tk(5);
    scl <= 1'b1;
    tk(5);
    sda_low <= 1'b1;
    tk(5);
    scl <= 1'b0;
    tk(1);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tk(5);
    scl <= 1'b1;
    tk(5);
    sda_low <= 1'b0;
    tk(5);
  endtask
  // One byte MSB first, then the acknowledge bit with the line released.
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({DEV_ADDR, 1'b0}, q, k0);
    xfer(a, q, k1);
    xfer(d, q, k2);
    stop();
    ok = k0 && k1 && k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    start();
    xfer({DEV_ADDR, 1'b0}, q, k);
    xfer(a, q, k);
    start();
    xfer({DEV_ADDR, 1'b1}, q, k);
    xfer(8'hff, q, k); // Released line; the last bit is the NACK.
    stop();
  endtask
endmodule

`default_nettype wire

// *** flash_driver_control_selftest_tb.sv ***
// Self-checking bench for the flash driver control top with a host model.
// Assumes a pulled-up data line shared by host and device.
`timescale 1ns/1ps
`default_nettype none

module flash_driver_control_selftest_tb;
  import fdc_pkg::*;
  localparam int STEP = 20; // Short duration step.
  logic sys_clk = 1'b0; // 40 MHz clock.
  logic resetn = 1'b0; // Reset, active low.
  logic scl, h_low, sda_in, sda_out, sda_oe; // Bus wires.
  logic [2:0] det = 3'h0; // Overvoltage, short, overtemperature.
  logic coil = 1'b0; // Broken coil level.
  logic boost_en, current_src_en, ok;
  fdc_mode_t led_mode;
  logic [7:0] led_current, q;
  int n_fail = 0;
  int n_compared = 0;
  always #12.5 sys_clk = ~sys_clk;
  assign sda_in = !(h_low || (sda_oe && !sda_out)); // Pull-up wins when released.
  fdc_top #(.STEP_CYCLES(STEP)) fdc_top_inst (.sys_clk(sys_clk), .resetn(resetn),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .ovp_detect(det[2]),
    .short_detect(det[1]), .overtemp_detect(det[0]), .boost_inductor_open(coil),
    .boost_en(boost_en), .current_src_en(current_src_en), .led_mode(led_mode),
    .led_current(led_current));
  fdc_host fdc_host_inst (.sys_clk(sys_clk), .sda_line(sda_in), .scl(scl), .sda_low(h_low));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Counts: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fdc_host_inst.wr(a, d, ok);
    check("ack", {7'h0, ok}, 8'h01);
  endtask
  // Bounded wait for shutdown, counting cycles.
  task automatic wait_off(output int n);
    n = 0;
    while (led_mode !== FDC_MODE_OFF) begin
      @(posedge sys_clk);
      n++;
      if (n > 1000) begin
        check("timeout", 8'h00, 8'h01);
        test_done();
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_selftest();
    check("reset current", led_current, FDC_CUR_RESET);
    fdc_host_inst.rd(FDC_ADDR_CTRL, q);
    check("reset control", q, FDC_CTRL_RESET);
    wr(FDC_ADDR_CTRL, 8'h20);
    check("assist", {4'h0, led_mode, boost_en, current_src_en}, 8'h0b);
    fdc_host_inst.rd(FDC_ADDR_CTRL, q);
    check("readback", q, 8'h20);
    wr(FDC_ADDR_CTRL, 8'h00);
    check("off", {4'h0, led_mode, boost_en, current_src_en}, 8'h00);
    fdc_host_inst.rd(FDC_ADDR_FAULT, q);
    check("fault", q, 8'h00);
    $display("selftest done");
  endtask
  task automatic t_flash();
    int n;
    wr(FDC_ADDR_UNLOCK, FDC_UNLOCK_KEY);
    wr(FDC_ADDR_CUR, 8'hff);
    check("current", led_current, 8'hff);
    wr(FDC_ADDR_CTRL, 8'h3f);
    check("flash", {6'h0, led_mode}, 8'h03);
    wait_off(n);
    // The wait starts after the stop, 26 cycles into the flash.
    check("length", {7'h0, n >= 16 * STEP - 30 && n <= 16 * STEP}, 8'h01);
    check("auto off", {7'h0, boost_en}, 8'h00);
    $display("flash done");
  endtask
  task automatic t_lock();
    wr(FDC_ADDR_UNLOCK, FDC_UNLOCK_KEY);
    wr(8'h10, 8'h55);
    wr(FDC_ADDR_CUR, 8'h00);
    check("locked", led_current, 8'h03);
    wr(FDC_ADDR_CTRL, 8'h90);
    check("ind", {6'h0, led_mode}, 8'h00);
    fdc_host_inst.rd(8'h10, q);
    check("unmapped", q, 8'h00);
    $display("lock done");
  endtask
  task automatic t_modes();
    int n;
    for (int m = 0; m < 4; m++) begin
      wr(FDC_ADDR_UNLOCK, FDC_UNLOCK_KEY);
      wr(FDC_ADDR_CTRL, {2'b00, m[1:0], 4'hf});
      check("mode", {6'h0, led_mode}, {6'h0, m[1:0]});
    end
    wait_off(n);
    $display("modes done");
  endtask
  task automatic t_fault();
    for (int k = 0; k < 3; k++) begin
      wr(FDC_ADDR_CTRL, 8'h20);
      det <= 3'h4 >> k;
      repeat (5) @(posedge sys_clk);
      det <= 3'h0;
      check("trip", {7'h0, boost_en}, 8'h00);
      fdc_host_inst.rd(FDC_ADDR_FAULT, q);
      check("flags", q, 8'h80 >> k);
    end
    wr(FDC_ADDR_CTRL, 8'h20);
    coil <= 1'b1;
    repeat (3) @(posedge sys_clk);
    coil <= 1'b0;
    fdc_host_inst.rd(FDC_ADDR_CTRL, q);
    check("coil", q, 8'h00);
    $display("fault done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_selftest();
    t_flash();
    t_lock();
    t_modes();
    t_fault();
    test_done();
  end
endmodule

`default_nettype wire
